// ---- verilog/jump_inc_map.vh ----
// constant map for the absolute jump and increment execute block
`ifndef JUMP_INC_MAP_VH
`define JUMP_INC_MAP_VH
`define OPC_JUMP_HI 8'hef
`define OPC_JUMP_W2 4'hf
`define OPC_INC 6'h0a
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3
`define PC_W 21
`define PC_RST 21'h000000
`define PC_STEP 21'h000002
`define ADDR_W 12
`define ACC_BANK_HI 4'h0
`define BSR_RST 4'h0
`define W_RST 8'h00
`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`define FLAG_OV 3
`define FLAG_N 4
`define STATUS_RST 5'h00
`endif

// ---- verilog/inc_alu.v ----
// increment arithmetic with flag generation
`timescale 1ns/100ps
`include "jump_inc_map.vh"
module inc_alu (
  input wire [7:0] operand,
  output wire [7:0] result,
  output wire [4:0] flags
);
  wire [8:0] sum;
  wire [4:0] nib;
  // full and low-nibble sums
  assign sum = {1'b0, operand} + 9'h001; // RULE_05
  assign nib = {1'b0, operand[3:0]} + 5'h01;
  assign result = sum[7:0];
  // flag vector: n, ov, z, dc, c
  assign flags[`FLAG_C] = sum[8]; // RULE_09
  assign flags[`FLAG_DC] = nib[4]; // RULE_09
  assign flags[`FLAG_Z] = (sum[7:0] == 8'h00); // RULE_09
  assign flags[`FLAG_OV] = ~operand[7] & sum[7]; // RULE_05
  assign flags[`FLAG_N] = sum[7]; // RULE_05
endmodule

// ---- verilog/abs_jump_and_increment_exec.v ----
// four-phase decode and execute of the absolute jump and register increment
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "jump_inc_map.vh"
// How it works
// RULE_01 - jump literal loads pc bits 20:1, bit0 zero
// RULE_02 - jump is two words, ef then f prefix
// RULE_03 - jump takes two cycles, flags untouched
// RULE_04 - any 20-bit literal reaches whole space
// RULE_05 - increment adds one, updates five flags
// RULE_06 - d=0 writes accumulator, d=1 writes register
// RULE_07 - a=0 uses access bank, ignores bank select
// RULE_08 - a=1 uses bank select with register field
// RULE_09 - 0xff wraps to zero, sets z c dc
// RULE_10 - lone second word is nop; prefetch discarded
module abs_jump_and_increment_exec (
  input wire ref_clk,
  input wire nrst,
  input wire [15:0] instr_word,
  input wire [15:0] next_word,
  input wire [3:0] bsr_in,
  input wire bsr_we,
  input wire [7:0] dmem_rdata,
  output reg [1:0] phase_ff,
  output reg [`PC_W-1:0] pc_ff,
  output reg [`ADDR_W-1:0] dmem_addr_ff,
  output reg [7:0] dmem_wdata_ff,
  output reg dmem_we_ff,
  output reg [7:0] w_reg_ff,
  output reg [4:0] status_ff,
  output reg [3:0] bank_select_register_ff,
  output reg flush_ff,
  output reg jump_busy_ff
);
  // next-state values of every output register
  reg [1:0] nxt_phase;
  reg [`PC_W-1:0] nxt_pc;
  reg [`ADDR_W-1:0] nxt_addr;
  reg [7:0] nxt_wdata;
  reg nxt_we;
  reg [7:0] nxt_w;
  reg [4:0] nxt_status;
  reg [3:0] nxt_bsr;
  reg nxt_flush;
  reg nxt_busy;
  // operand and low literal latched in q2
  reg [7:0] operand_ff;
  reg [7:0] nxt_operand;
  reg [7:0] lit_lo_ff;
  reg [7:0] nxt_lit_lo;
  // alu results and decode strobes
  wire [7:0] inc_res;
  wire [4:0] inc_flags;
  wire is_jump;
  wire is_inc;
  wire is_w2;

  // increment datapath
  inc_alu u_alu (
    .operand(operand_ff),
    .result(inc_res),
    .flags(inc_flags)
  );

  // opcode decode of the word in execution
  assign is_jump = (instr_word[15:8] == `OPC_JUMP_HI); // RULE_02
  assign is_inc = (instr_word[15:10] == `OPC_INC); // RULE_05
  assign is_w2 = (instr_word[15:12] == `OPC_JUMP_W2); // RULE_10

  // data address from access and bank bits
  function [`ADDR_W-1:0] data_addr;
    input a_bit;
    input [3:0] bank;
    input [7:0] f;
    begin
      if (a_bit) begin
        data_addr = {bank, f}; // RULE_08
      end else begin
        data_addr = {`ACC_BANK_HI, f}; // RULE_07
      end
    end
  endfunction

  // phase sequencing and execution
  always @* begin
    nxt_phase = phase_ff + 2'h1;
    nxt_pc = pc_ff;
    nxt_addr = dmem_addr_ff;
    nxt_wdata = dmem_wdata_ff;
    nxt_we = 1'b0;
    nxt_w = w_reg_ff;
    nxt_status = status_ff;
    nxt_bsr = bsr_we ? bsr_in : bank_select_register_ff;
    nxt_flush = 1'b0;
    nxt_busy = jump_busy_ff;
    nxt_operand = operand_ff;
    nxt_lit_lo = lit_lo_ff;
    case (phase_ff)
      `PH_Q1: begin
        // decode; address is formed for the read
        if (!jump_busy_ff && is_inc) begin
          nxt_addr = data_addr(instr_word[8], bank_select_register_ff, instr_word[7:0]);
        end
      end
      `PH_Q2: begin
        // low literal byte or the register operand is latched
        if (!jump_busy_ff && is_jump) begin
          nxt_lit_lo = instr_word[7:0]; // RULE_02
        end else if (!jump_busy_ff && is_inc) begin
          nxt_operand = dmem_rdata;
        end
      end
      `PH_Q3: begin
        // increment result settles through the alu
      end
      `PH_Q4: begin
        // results land at the edge that closes the instruction cycle
        if (jump_busy_ff) begin
          nxt_busy = 1'b0; // RULE_03
        end else if (is_jump) begin
          nxt_pc = {next_word[11:0], lit_lo_ff, 1'b0}; // RULE_01 RULE_04
          nxt_busy = 1'b1; // RULE_03
          nxt_flush = 1'b1; // RULE_10
        end else if (is_inc) begin
          nxt_status = inc_flags; // RULE_05 RULE_09
          nxt_pc = pc_ff + `PC_STEP;
          if (instr_word[9]) begin
            nxt_wdata = inc_res; // RULE_06
            nxt_we = 1'b1;
          end else begin
            nxt_w = inc_res; // RULE_06
          end
        end else if (is_w2) begin
          nxt_pc = pc_ff + `PC_STEP; // RULE_10
        end else begin
          nxt_pc = pc_ff + `PC_STEP;
        end
      end
      default: begin
        nxt_phase = `PH_Q1;
      end
    endcase
  end

  // phase counter, free running through q1..q4
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= `PH_Q1;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // program counter
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pc_ff <= `PC_RST;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // data memory port
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dmem_addr_ff <= {`ADDR_W{1'b0}};
      dmem_wdata_ff <= 8'h00;
      dmem_we_ff <= 1'b0;
    end else begin
      dmem_addr_ff <= nxt_addr;
      dmem_wdata_ff <= nxt_wdata;
      dmem_we_ff <= nxt_we;
    end
  end

  // working accumulator
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      w_reg_ff <= `W_RST;
    end else begin
      w_reg_ff <= nxt_w;
    end
  end

  // status flags, only the increment writes them
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status_ff <= `STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // bank select, loaded from the side port
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bank_select_register_ff <= `BSR_RST;
    end else begin
      bank_select_register_ff <= nxt_bsr;
    end
  end

  // jump control: flush pulse, busy cycle, low literal
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flush_ff <= 1'b0;
      jump_busy_ff <= 1'b0;
      lit_lo_ff <= 8'h00;
    end else begin
      flush_ff <= nxt_flush;
      jump_busy_ff <= nxt_busy;
      lit_lo_ff <= nxt_lit_lo;
    end
  end

  // increment operand
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      operand_ff <= 8'h00;
    end else begin
      operand_ff <= nxt_operand;
    end
  end
endmodule

// ---- dv/ji_sva.sv ----
// port assertions for the jump and increment execute block
`timescale 1ns/100ps
module ji_sva (
  input wire ref_clk,
  input wire nrst,
  input wire [15:0] instr_word,
  input wire [15:0] next_word,
  input wire [3:0] bank_select_register_ff,
  input wire [1:0] phase_ff,
  input wire [20:0] pc_ff,
  input wire [11:0] dmem_addr_ff,
  input wire dmem_we_ff,
  input wire [4:0] status_ff,
  input wire flush_ff,
  input wire jump_busy_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // decode; a busy cycle ignores the word
  wire inc = instr_word[15:10] == 6'h0a && !jump_busy_ff;
  wire jmp = phase_ff == 2'h3 && instr_word[15:8] == 8'hef && !jump_busy_ff;
  a_pc_even: assert property (pc_ff[0] == 1'h0) else $error("odd pc");
  a_jump_target: assert property (
    jmp |=> pc_ff == {$past(next_word[11:0]), $past(instr_word[7:0]), 1'h0}) else $error("pc");
  a_jump_flags: assert property (jmp |=> $stable(status_ff)) else $error("flags");
  a_jump_busy: assert property (
    jmp |=> jump_busy_ff [*4] ##1 !jump_busy_ff) else $error("busy");
  a_flush_pulse: assert property (jmp |=> flush_ff ##1 !flush_ff) else $error("flush");
  a_nop_hold: assert property (
    jump_busy_ff && phase_ff == 2'h3 |=> $stable(pc_ff)) else $error("pc moved");
  a_write_dest: assert property (
    inc && phase_ff == 2'h3 |=> dmem_we_ff == $past(instr_word[9])) else $error("dest");
  a_bank_addr: assert property (
    inc && phase_ff == 2'h1 |-> dmem_addr_ff ==
    {instr_word[8] ? $past(bank_select_register_ff) : 4'h0, instr_word[7:0]}) else $error("addr");
endmodule
bind abs_jump_and_increment_exec ji_sva chk (.*);

// ---- dv/prog_mem_model.sv ----
// program memory model fetching words at the program counter
`timescale 1ns/100ps
module prog_mem_model (
  input wire [20:0] pc_ff,
  output wire [15:0] instr_word,
  output wire [15:0] next_word
);
  reg [15:0] mem [0:63];
  // current word and the word after it
  assign instr_word = mem[pc_ff[6:1]];
  assign next_word = mem[pc_ff[6:1] + 6'h1];
endmodule

// ---- dv/tb_abs_jump_and_increment_exec.sv ----
// bench for the jump and increment execute block
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t bad", $time); end end
module tb_abs_jump_and_increment_exec;
  reg ref_clk = 1'h0, nrst = 1'h0, bsr_we = 1'h0;
  reg [3:0] bsr_in = 4'h0;
  reg [7:0] dmem_rdata = 8'h0, d, f;
  reg [19:0] lit;
  wire [15:0] instr_word, next_word;
  wire [20:0] pc_ff;
  wire [11:0] dmem_addr_ff;
  wire [7:0] dmem_wdata_ff, w_reg_ff;
  wire [4:0] status_ff;
  wire [3:0] bank_select_register_ff;
  wire [1:0] phase_ff;
  wire dmem_we_ff, flush_ff, jump_busy_ff;
  integer num_errors = 0, checks = 0, cycles = 0, seed = 32'h324a950b;
  abs_jump_and_increment_exec i_abs_jump_and_increment_exec (.*);
  prog_mem_model pm (.pc_ff(pc_ff), .instr_word(instr_word), .next_word(next_word));
  // clock and hang guard
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cycles > 200) begin num_errors++; final_report; end
  // increment flags n, ov, z, dc, c
  function [4:0] flg(input [7:0] v);
    flg = {v + 8'h1 > 8'h7f, v == 8'h7f, v == 8'hff, v[3:0] == 4'hf, v == 8'hff};
  endfunction
  task q(input integer n); begin
    repeat (n) @(posedge ref_clk);
    #1;
  end endtask
  task final_report; begin
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end endtask
  // program: nop, two increments, jump, lone second word at the target
  initial begin
    d = $random(seed);
    f = $random(seed);
    lit = $random(seed);
    lit[5:4] = 2'h3;
    bsr_in <= $random(seed);
    pm.mem[0] = 16'h0;
    pm.mem[1] = {6'h0a, 2'h3, f};
    pm.mem[2] = {6'h0a, 2'h0, ~f};
    pm.mem[3] = {8'hef, lit[7:0]};
    pm.mem[4] = {4'hf, lit[19:8]};
    pm.mem[lit[5:0]] = 16'hf5a5;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'h1;
    bsr_we <= 1'h1;
    @(posedge ref_clk) bsr_we <= 1'h0;
    repeat (3) @(posedge ref_clk);
    dmem_rdata <= d;
    q(1); `CHK(dmem_addr_ff, {bsr_in, f})
    `CHK({phase_ff, bank_select_register_ff}, {2'h1, bsr_in})
    q(3); `CHK({dmem_we_ff, dmem_wdata_ff, status_ff}, {1'h1, d + 8'h1, flg(d)})
    @(posedge ref_clk) dmem_rdata <= 8'hff;
    #1 `CHK(dmem_addr_ff, {4'h0, ~f})
    q(3); `CHK({dmem_we_ff, w_reg_ff, status_ff}, 14'h7)
    q(4); `CHK({flush_ff, jump_busy_ff, pc_ff, status_ff}, {2'h3, lit, 1'h0, 5'h7})
    q(4); `CHK({flush_ff, jump_busy_ff, pc_ff}, {2'h0, lit, 1'h0})
    q(4); `CHK(pc_ff, {lit, 1'h0} + 21'h2)
    final_report;
  end
endmodule
